// ==== rtl/control_location_arbiter.sv ====
`timescale 1ns/1ps
module control_location_arbiter
	import arbiter_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic analogRemote_n, // Takeover pin, low requests remote
	input wire logic panelLock, // Allow-remote inhibit from panel
	input wire logic [NUM_PORTS-1:0] remoteReq, // Pulse: port asks for remote control
	input wire logic [NUM_PORTS-1:0] remoteRel, // Pulse: port gives up remote control
	input wire logic [NUM_PORTS-1:0] msgGood, // Pulse: complete well-formed message
	input wire logic [NUM_PORTS-1:0] supvCmdValid, // Pulse: supervision command
	input wire logic [NUM_PORTS-1:0] supvCmdEnable, // Enable value of that command
	input wire logic [NUM_PORTS-1:0] tmoWrValid, // Pulse: new timeout written
	input wire logic [TMO_W-1:0] tmoWrData, // Timeout value in ticks
	input wire logic stayOnAfterRemote, // Stored after-remote parameter, 1 keeps output on
	input wire logic outputOn, // Output currently on
	output logic [1:0] location, // Current control location
	output logic [PORT_W-1:0] ctrlPort, // Port holding digital control
	output logic [NUM_PORTS-1:0] reqError, // Pulse: request refused, per port
	output logic [NUM_PORTS-1:0] reqAck, // Pulse: request granted, per port
	output logic panelAdjustAllowed, // Panel may adjust set values
	output logic [NUM_PORTS-1:0] remoteAdjustAllowed, // Port may adjust set values
	output logic outputOffReq, // Pulse: switch output off after timeout
	output logic timeoutEvent, // Pulse: supervision expired
	output logic supvEnabled // Supervision enable state
);
	supv_if sv();

	logic pinMeta_r, pinSync_r; // Takeover pin synchroniser
	logic lockMeta_r, lockSync_r; // Lock synchroniser
	location_t loc_r, loc_nxt; // Control location
	logic [PORT_W-1:0] port_r, port_nxt; // Holding port index
	logic supvEn_r, supvEn_nxt; // Supervision enable
	logic [TMO_W-1:0] reload_r, reload_nxt; // Pending timeout value
	logic [NUM_PORTS-1:0] err_r, err_nxt; // Refusal pulses
	logic [NUM_PORTS-1:0] ack_r, ack_nxt; // Grant pulses
	logic offReq_r, offReq_nxt; // Output-off pulse
	logic tmoEv_r, tmoEv_nxt; // Timeout event pulse
	logic panelAdj_r, panelAdj_nxt; // Panel adjust permission
	logic [NUM_PORTS-1:0] remAdj_r, remAdj_nxt; // Remote adjust permission
	logic analogWant; // Pin asks for analog remote
	logic lockOn; // Panel-only lock set

	// Lowest-numbered asserted bit wins
	function automatic logic [PORT_W-1:0] firstBit(input logic [NUM_PORTS-1:0] v);
		logic [PORT_W-1:0] idx;
		idx = '0;
		for (int i = NUM_PORTS - 1; i >= 0; i--)
		begin
			if (v[i])
			begin
				idx = PORT_W'(i);
			end
		end
		return idx;
	endfunction

	// Two-flop synchronisers for the external levels
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pinMeta_r <= 1'b1;
			pinSync_r <= 1'b1;
			lockMeta_r <= 1'b0;
			lockSync_r <= 1'b0;
		end
		else
		begin
			pinMeta_r <= analogRemote_n;
			pinSync_r <= pinMeta_r;
			lockMeta_r <= panelLock;
			lockSync_r <= lockMeta_r;
		end
	end

	assign analogWant = !pinSync_r;
	assign lockOn = lockSync_r;

	// Location arbitration and supervision settings
	always_comb
	begin
		loc_nxt = loc_r;
		port_nxt = port_r;
		supvEn_nxt = supvEn_r;
		reload_nxt = reload_r;
		err_nxt = '0;
		ack_nxt = '0;
		offReq_nxt = 1'b0;
		tmoEv_nxt = 1'b0;
		// Supervision commands from any port at any time
		if (|supvCmdValid)
		begin
			supvEn_nxt = supvCmdEnable[firstBit(supvCmdValid)];
		end
		if (|tmoWrValid)
		begin
			reload_nxt = tmoWrData;
		end
		case (loc_r)
			LOC_PANEL:
			begin
				if (lockOn)
				begin
					loc_nxt = LOC_LOCAL;
					err_nxt = remoteReq;
				end
				else if (analogWant)
				begin
					loc_nxt = LOC_ANALOG;
					err_nxt = remoteReq;
				end
				else if (|remoteReq)
				begin
					loc_nxt = LOC_DIGITAL;
					port_nxt = firstBit(remoteReq);
					ack_nxt = NUM_PORTS'(1) << firstBit(remoteReq);
					err_nxt = remoteReq & ~ack_nxt;
				end
			end
			LOC_ANALOG:
			begin
				err_nxt = remoteReq;
				if (lockOn)
				begin
					loc_nxt = LOC_LOCAL;
				end
				else if (!analogWant)
				begin
					loc_nxt = LOC_PANEL;
				end
			end
			LOC_DIGITAL:
			begin
				// Analog pin has no effect here
				err_nxt = remoteReq & ~(NUM_PORTS'(1) << port_r);
				ack_nxt = remoteReq & (NUM_PORTS'(1) << port_r);
				if (lockOn)
				begin
					loc_nxt = LOC_LOCAL;
				end
				else if (sv.expired)
				begin
					loc_nxt = LOC_PANEL;
					tmoEv_nxt = 1'b1;
					offReq_nxt = outputOn && !stayOnAfterRemote;
				end
				else if (remoteRel[port_r])
				begin
					loc_nxt = LOC_PANEL;
				end
			end
			LOC_LOCAL:
			begin
				err_nxt = remoteReq;
				if (!lockOn)
				begin
					// Analog resumes only if pin still low; digital must ask again
					loc_nxt = analogWant ? LOC_ANALOG : LOC_PANEL;
				end
			end
			default:
			begin
				loc_nxt = LOC_PANEL;
			end
		endcase
		// Adjust permissions follow the next location
		panelAdj_nxt = (loc_nxt == LOC_PANEL) || (loc_nxt == LOC_LOCAL);
		remAdj_nxt = (loc_nxt == LOC_DIGITAL) ? (NUM_PORTS'(1) << port_nxt) : '0;
	end

	// Register arbitration state
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loc_r <= LOC_PANEL;
			port_r <= '0;
			supvEn_r <= SUPV_EN_RESET;
			reload_r <= TMO_RESET;
			err_r <= '0;
			ack_r <= '0;
			offReq_r <= 1'b0;
			tmoEv_r <= 1'b0;
			panelAdj_r <= 1'b1;
			remAdj_r <= '0;
		end
		else
		begin
			loc_r <= loc_nxt;
			port_r <= port_nxt;
			supvEn_r <= supvEn_nxt;
			reload_r <= reload_nxt;
			err_r <= err_nxt;
			ack_r <= ack_nxt;
			offReq_r <= offReq_nxt;
			tmoEv_r <= tmoEv_nxt;
			panelAdj_r <= panelAdj_nxt;
			remAdj_r <= remAdj_nxt;
		end
	end

	// Supervisor hookup; own timer, unrelated to any network timeout
	assign sv.active = (loc_r == LOC_DIGITAL) && supvEn_r;
	assign sv.restart = msgGood[port_r];
	assign sv.reload = reload_r;

	link_supervisor u_supv
	(
		.clk(clk),
		.rst_n(rst_n),
		.sv(sv)
	);

	// Outputs straight from flops; status reads are never gated
	assign location = loc_r;
	assign ctrlPort = port_r;
	assign reqError = err_r;
	assign reqAck = ack_r;
	assign panelAdjustAllowed = panelAdj_r;
	assign remoteAdjustAllowed = remAdj_r;
	assign outputOffReq = offReq_r;
	assign timeoutEvent = tmoEv_r;
	assign supvEnabled = supvEn_r;
endmodule

// ==== rtl/arbiter_pkg.sv ====
package arbiter_pkg;
	// Number of digital ports that may take remote control
	localparam int NUM_PORTS = 4;
	// Width of a port index
	localparam int PORT_W = 2;
	// Width of the supervision timeout counter in block clock ticks
	localparam int TMO_W = 24;
	// Reset value of the timeout reload in ticks
	localparam logic [23:0] TMO_RESET = 24'h0f4240;
	// Reset value of the supervision enable
	localparam logic SUPV_EN_RESET = 1'b0;
	// Control locations
	typedef enum logic [1:0] {LOC_PANEL, LOC_ANALOG, LOC_DIGITAL, LOC_LOCAL} location_t;
endpackage

// ==== rtl/supv_if.sv ====
`timescale 1ns/1ps
// Signals between the arbiter and its link supervisor
interface supv_if;
	import arbiter_pkg::*;
	logic active; // Digital remote control held and supervision on
	logic restart; // Complete message seen on the held port
	logic [TMO_W-1:0] reload; // Timeout period for the next run
	logic expired; // One-cycle pulse when the period runs out
	modport arb (output active, output restart, output reload, input expired);
	modport supv (input active, input restart, input reload, output expired);
endinterface

// ==== rtl/link_supervisor.sv ====
`timescale 1ns/1ps
// Watchdog that counts block clock ticks between messages
module link_supervisor
	import arbiter_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	supv_if.supv sv
);
	logic [TMO_W-1:0] count_r, count_nxt; // Ticks left in current period
	logic [TMO_W-1:0] period_r, period_nxt; // Period now in force
	logic expired_r, expired_nxt; // Expiry pulse

	// Next-state of the down counter
	always_comb
	begin
		count_nxt = count_r;
		period_nxt = period_r;
		expired_nxt = 1'b0;
		if (!sv.active)
		begin
			// Idle: reload so a new run starts full
			period_nxt = sv.reload;
			count_nxt = sv.reload;
		end
		else if (sv.restart)
		begin
			count_nxt = period_r;
		end
		else if (count_r <= TMO_W'(1))
		begin
			// Period elapsed: expire and take any new value
			expired_nxt = 1'b1;
			period_nxt = sv.reload;
			count_nxt = sv.reload;
		end
		else
		begin
			count_nxt = count_r - TMO_W'(1);
		end
	end

	// Register the counter
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count_r <= TMO_RESET;
			period_r <= TMO_RESET;
			expired_r <= 1'b0;
		end
		else
		begin
			count_r <= count_nxt;
			period_r <= period_nxt;
			expired_r <= expired_nxt;
		end
	end

	assign sv.expired = expired_r;
endmodule

// ==== test/host_model.sv ====
`timescale 1ns/1ps
// Host that sends one good message every GAP cycles while on
module host_model #(parameter int GAP = 5)
(
	input wire logic clk,
	input wire logic on,
	output logic msg
);
	int cnt = 0; // Cycles since the last message
	logic msgPulse_r = 1'b0; // Message pulse, single driver
	// Steady message pace; silent when off
	always @(posedge clk)
	begin
		cnt <= (on && cnt < GAP - 1) ? cnt + 1 : 0;
		msgPulse_r <= on && cnt == GAP - 1;
	end
	assign msg = msgPulse_r;
endmodule

// ==== test/arbiter_props.sv ====
`timescale 1ns/1ps
// Location and supervisor checks at the arbiter ports
module arbiter_props
	import arbiter_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic analogRemote_n,
	input wire logic panelLock,
	input wire logic [NUM_PORTS-1:0] remoteReq,
	input wire logic [NUM_PORTS-1:0] remoteRel,
	input wire logic [NUM_PORTS-1:0] msgGood,
	input wire logic stayOnAfterRemote,
	input wire logic outputOn,
	input wire logic [1:0] location,
	input wire logic [PORT_W-1:0] ctrlPort,
	input wire logic [NUM_PORTS-1:0] reqError,
	input wire logic [NUM_PORTS-1:0] reqAck,
	input wire logic panelAdjustAllowed,
	input wire logic [NUM_PORTS-1:0] remoteAdjustAllowed,
	input wire logic outputOffReq,
	input wire logic timeoutEvent,
	input wire logic supvEnabled
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Pins quiet long enough for the synchronisers to agree
	sequence freePins;
		(!panelLock && analogRemote_n)[*4];
	endsequence
	sequence pinLow;
		(!panelLock && !analogRemote_n && remoteReq == 4'h0)[*4];
	endsequence
	a_one_remote: assert property (location == LOC_DIGITAL |->
		remoteAdjustAllowed == 4'h1 << ctrlPort && !panelAdjustAllowed) else $error("two remote owners");
	a_analog_refuse: assert property (location == LOC_ANALOG && |remoteReq |=>
		reqError == $past(remoteReq)) else $error("request not refused in analog");
	a_digital_keep: assert property (location == LOC_DIGITAL && remoteRel == 4'h0 |=>
		location != LOC_ANALOG) else $error("pin took over digital");
	a_panel_grant: assert property (freePins ##0 location == LOC_PANEL && $onehot(remoteReq) |=>
		reqAck == $past(remoteReq)) else $error("request not granted");
	a_local_panel: assert property (location == LOC_LOCAL |->
		panelAdjustAllowed && remoteAdjustAllowed == 4'h0) else $error("remote adjust in local");
	a_local_refuse: assert property (location == LOC_LOCAL && |remoteReq |=>
		reqError == $past(remoteReq)) else $error("request not refused in local");
	a_entry_req: assert property (location != LOC_DIGITAL ##1 location == LOC_DIGITAL |->
		$past(remoteReq) != 4'h0) else $error("digital without request");
	a_tmo_cause: assert property (timeoutEvent |->
		$past(location) == LOC_DIGITAL && $past(supvEnabled)) else $error("timeout while unsupervised");
	a_msg_restart: assert property (location == LOC_DIGITAL && msgGood[ctrlPort] |=>
		!timeoutEvent[*3]) else $error("timeout right after message");
	a_tmo_exit: assert property (timeoutEvent |-> location == LOC_PANEL &&
		outputOffReq == ($past(outputOn) && !$past(stayOnAfterRemote))) else $error("bad timeout reaction");
	a_pin_take: assert property (pinLow ##0 location == LOC_PANEL |=>
		location == LOC_ANALOG) else $error("pin low not taken");
endmodule
bind control_location_arbiter arbiter_props chk (.*);

// ==== test/tb_control_location_arbiter.sv ====
`timescale 1ns/1ps
// Walks takeover, lock and supervision sequences
module tb_control_location_arbiter
	import arbiter_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic anaPin_n = 1'b1, lock = 1'b0, hostOn = 1'b0, stayOn = 1'b0, outOn = 1'b1;
	logic [NUM_PORTS-1:0] req = '0, rel = '0, svV = '0, svE = '0, twV = '0;
	logic [TMO_W-1:0] twD = '0;
	wire hostMsg;
	logic [1:0] loc;
	logic [PORT_W-1:0] port;
	logic [NUM_PORTS-1:0] err, ack, remAdj;
	logic panAdj, offReq, tmo, supEn;
	int nFail = 0, checkCount = 0;
	always #10 clk = ~clk;
	host_model host (.clk(clk), .on(hostOn), .msg(hostMsg));
	control_location_arbiter uut (.clk(clk), .rst_n(rst_n), .analogRemote_n(anaPin_n), .panelLock(lock),
		.remoteReq(req), .remoteRel(rel), .msgGood({2'h0, hostMsg, 1'b0}), .supvCmdValid(svV),
		.supvCmdEnable(svE), .tmoWrValid(twV), .tmoWrData(twD), .stayOnAfterRemote(stayOn), .outputOn(outOn),
		.location(loc), .ctrlPort(port), .reqError(err), .reqAck(ack), .panelAdjustAllowed(panAdj),
		.remoteAdjustAllowed(remAdj), .outputOffReq(offReq), .timeoutEvent(tmo), .supvEnabled(supEn));
	// Compare and count
	task chk(input logic [7:0] s, input logic [7:0] e);
		checkCount++;
		if (s !== e)
		begin
			nFail++;
			$display("Error at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Wait n edges, then settle
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// One-cycle request pulse and its answer
	task ask(input int p, input logic [3:0] eAck, input logic [3:0] eErr);
		@(posedge clk) req <= 4'h1 << p;
		@(posedge clk) req <= '0;
		#1;
		chk(ack, eAck);
		chk(err, eErr);
	endtask
	// Cycles until timeout, up to lim
	task waitTmo(input int lim, output int n);
		for (n = 0; n < lim && tmo !== 1'b1; n++)
			wt(1);
	endtask
	// Main sequence
	initial
	begin
		int n;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk(loc, LOC_PANEL);
		chk(supEn, SUPV_EN_RESET);
		@(posedge clk) {twV, svV, svE, twD, hostOn} <= {4'h2, 4'h2, 4'h2, 24'h8, 1'b1};
		@(posedge clk) {twV, svV} <= '0;
		wt(1);
		chk(supEn, 1);
		waitTmo(20, n);
		chk(n, 20);
		ask(1, 4'h2, 4'h0);
		chk(remAdj, 4'h2);
		chk(port, 1);
		ask(2, 4'h0, 4'h4);
		@(posedge clk) anaPin_n <= 1'b0;
		wt(6);
		chk(loc, LOC_DIGITAL);
		waitTmo(40, n);
		chk(n, 40);
		@(posedge clk) {twV, twD, hostOn} <= {4'h2, 24'h1e, 1'b0};
		@(posedge clk) twV <= '0;
		waitTmo(40, n);
		chk(n < 12, 1);
		chk({tmo, offReq, loc}, {2'h3, LOC_PANEL});
		wt(2);
		chk(loc, LOC_ANALOG);
		ask(0, 4'h0, 4'h1);
		@(posedge clk) lock <= 1'b1;
		wt(5);
		chk({loc, panAdj}, {LOC_LOCAL, 1'b1});
		ask(3, 4'h0, 4'h8);
		@(posedge clk) lock <= 1'b0;
		wt(5);
		chk(loc, LOC_ANALOG);
		@(posedge clk) anaPin_n <= 1'b1;
		wt(5);
		chk(loc, LOC_PANEL);
		ask(0, 4'h1, 4'h0);
		// Messages on a port without control must not keep it alive; new period now in force
		@(posedge clk) {hostOn, stayOn} <= 2'b11;
		waitTmo(40, n);
		chk(n > 25 && n < 40, 1);
		chk({tmo, offReq, loc}, {2'h2, LOC_PANEL});
		// Supervision switched off: digital control never times out
		@(posedge clk) {svV, svE} <= {4'h1, 4'h0};
		@(posedge clk) svV <= '0;
		wt(1);
		chk(supEn, 0);
		ask(2, 4'h4, 4'h0);
		chk(port, 2);
		waitTmo(40, n);
		chk(n, 40);
		// Holding port gives control back to the panel
		@(posedge clk) rel <= 4'h4;
		@(posedge clk) rel <= '0;
		wt(1);
		chk(loc, LOC_PANEL);
		ask(0, 4'h1, 4'h0);
		@(posedge clk) lock <= 1'b1;
		wt(5);
		@(posedge clk) lock <= 1'b0;
		wt(5);
		chk(loc, LOC_PANEL);
		chk(remAdj, 4'h0);
		report_and_stop;
	end
	// Hang guard
	initial
	begin
		#100us;
		nFail++;
		report_and_stop;
	end
endmodule
